// ===== hdl/rc_capture_consts.vh
// Constants for the radio-control pulse command capture block
`ifndef RC_CAPTURE_CONSTS_VH
`define RC_CAPTURE_CONSTS_VH

// ----------------------------------------
// Clock and nominal pulse widths
// ----------------------------------------
`define RC_CLK_HZ          10000000
`define RC_NOM_MIN_US      1000
`define RC_NOM_CEN_US      1500
`define RC_NOM_MAX_US      2000
// One timing tick of 1 us; 0.4% of 1000 us travel is 4 us, so 1 us resolves it
`define RC_TICK_US         1
`define RC_TICK_CYC        ((`RC_CLK_HZ / 1000000) * `RC_TICK_US)

// ----------------------------------------
// Default references in microseconds
// ----------------------------------------
`define RC_DEF_MIN         12'h3E8
`define RC_DEF_CEN         12'h5DC
`define RC_DEF_MAX         12'h7D0

// ----------------------------------------
// Plausibility window in microseconds
// ----------------------------------------
`define RC_PLAUS_MIN       12'h2BC
`define RC_PLAUS_MAX       12'h9C4

// ----------------------------------------
// Watchdog timing in milliseconds, and qualifying pulse count
// ----------------------------------------
`define RC_QUAL_MS         500
`define RC_LOSS_MS         250
`define RC_QUAL_PULSES     8'h10

// ----------------------------------------
// Deadband
// ----------------------------------------
`define RC_DB_DEFAULT      3'h2
`define RC_CMD_FULL        8'h7F

`endif

// ===== hdl/rc_width_meter.v
// Measures the high time of one receiver pulse channel in microsecond ticks
`timescale 1ns/1ps
`include "rc_capture_consts.vh"

module rc_width_meter #(
   parameter W = 12
) (
   input  wire         clk,
   input  wire         resetn,
   input  wire         tick,
   input  wire         pulse_in,
   output reg  [W-1:0] width,
   output reg          done,
   output reg          plausible
);

   reg         pulse_d;
   reg [W-1:0] count;
   reg         ovf;

   // ----------------------------------------
   // Edge timing
   // ----------------------------------------
   // Saturating counter; an overrun pulse is flagged implausible, not wrapped
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pulse_d   <= 1'b0;
         count     <= {W{1'b0}};
         ovf       <= 1'b0;
         width     <= {W{1'b0}};
         done      <= 1'b0;
         plausible <= 1'b0;
      end else begin
         pulse_d <= pulse_in;
         done    <= 1'b0;
         // (R1) rise cycle counts too, so N cycles give exact ticks
         if (pulse_in && !pulse_d) begin
            count <= {{(W-1){1'b0}}, tick};
            ovf   <= 1'b0;
         end else if (pulse_in && tick) begin
            if (&count)
               ovf <= 1'b1;
            else
               count <= count + 1'b1;
         end
         if (!pulse_in && pulse_d) begin
            width     <= count;
            done      <= 1'b1;
            // (R19) reject wild widths
            plausible <= !ovf && (count >= `RC_PLAUS_MIN) && (count <= `RC_PLAUS_MAX);
         end
      end
   end

endmodule

// ===== hdl/rc_pulse_command_capture.v
// Two-channel R/C pulse capture with deadband, watchdog and accessory switch
// How it works
// (R1) Pulse widths 1.0/1.5/2.0 ms encode stick
// (R2) One microsecond ticks resolve 0.4% travel
// (R3) Width versus references gives -127..+127 command
// (R4) References default, loadable and savable as defaults; saved set is never read, reset loads the constants
// (R5) Motors disabled while no pulses arrive
// (R6) Regular pulses over qualification period enable motors
// (R7) Loss timeout after pulses stop disables motors
// (R8) Pulses returning in time keep motors enabled
// (R9) Confirmed loss forces accessory off, flags lost
// (R10) Three-bit deadband code, zero disables it
// (R11) Codes 1-7 give 8..54 percent deadband
// (R12) Deadband code defaults to two
// (R13) One deadband setting for both channels
// (R14) Stick inside deadband gives zero command
// (R15) Outside deadband rescale to full command
// (R16) Optional curve selection on command
// (R17) Mixed mode side trim up to ten percent
// (R18) Channel three max sets, center clears accessory
// (R19) Implausible pulses ignored by the watchdog
`timescale 1ns/1ps
`include "rc_capture_consts.vh"

module rc_pulse_command_capture #(
   parameter W       = 12,
   parameter QUAL_MS = `RC_QUAL_MS,
   parameter LOSS_MS = `RC_LOSS_MS,
   parameter TICK_CYC = `RC_TICK_CYC
) (
   input  wire         clk,
   input  wire         resetn,
   input  wire         ch1_pulse,
   input  wire         ch2_pulse,
   input  wire         ch3_pulse,
   input  wire [W-1:0] cfg_min,
   input  wire [W-1:0] cfg_cen,
   input  wire [W-1:0] cfg_max,
   input  wire         cfg_load,
   input  wire         cfg_save,
   input  wire [2:0]   cfg_deadband,
   input  wire         cfg_deadband_load,
   input  wire [2:0]   curve_sel,
   input  wire         mixed_mode,
   input  wire         trim_left,
   input  wire [3:0]   trim_pct,
   output reg  [W-1:0] ref_min,
   output reg  [W-1:0] ref_cen,
   output reg  [W-1:0] ref_max,
   output reg  [2:0]   deadband_code,
   output reg  [7:0]   cmd1,
   output reg  [7:0]   cmd2,
   output reg          cmd_valid,
   output reg          motors_enabled,
   output reg          signal_lost,
   output reg          accessory_on
);

   // ----------------------------------------
   // Timing constants
   // ----------------------------------------
   localparam integer TICKS_PER_MS = 1000 / `RC_TICK_US;
   localparam integer QUAL_TICKS   = QUAL_MS * TICKS_PER_MS;
   localparam integer LOSS_TICKS   = LOSS_MS * TICKS_PER_MS;
   localparam integer TICK_LAST_I = TICK_CYC - 1;
   localparam [3:0] TICK_LAST = TICK_LAST_I[3:0];

   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_QUAL = 2'd1;
   localparam [1:0] ST_RUN  = 2'd2;
   localparam [1:0] ST_LOSS = 2'd3;

   // ----------------------------------------
   // Microsecond tick
   // ----------------------------------------
   reg [3:0] tick_div;
   reg       tick;
   // (R2) one us resolution tick
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_div <= 4'h0;
         tick     <= 1'b0;
      end else begin
         tick     <= (tick_div == TICK_LAST);
         tick_div <= (tick_div == TICK_LAST) ? 4'h0 : tick_div + 4'h1;
      end
   end

   // ----------------------------------------
   // Width meters, one per channel
   // ----------------------------------------
   wire [W-1:0] wid [0:2];
   wire [2:0]   wdone;
   wire [2:0]   wok;
   wire [2:0]   pin = {ch3_pulse, ch2_pulse, ch1_pulse};

   // (R1) width in ticks per channel
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : meter
         rc_width_meter #(.W(W)) u_meter (
            .clk       (clk),
            .resetn    (resetn),
            .tick      (tick),
            .pulse_in  (pin[g]),
            .width     (wid[g]),
            .done      (wdone[g]),
            .plausible (wok[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // References and deadband setting
   // ----------------------------------------
   reg [W-1:0] def_min;
   reg [W-1:0] def_cen;
   reg [W-1:0] def_max;
   reg [2:0]   def_db;
   // (R4) working and saved references
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         def_min       <= `RC_DEF_MIN;
         def_cen       <= `RC_DEF_CEN;
         def_max       <= `RC_DEF_MAX;
         def_db        <= `RC_DB_DEFAULT;
         ref_min       <= `RC_DEF_MIN;
         ref_cen       <= `RC_DEF_CEN;
         ref_max       <= `RC_DEF_MAX;
         // (R12) default code two
         deadband_code <= `RC_DB_DEFAULT;
      end else begin
         if (cfg_load) begin
            ref_min <= cfg_min;
            ref_cen <= cfg_cen;
            ref_max <= cfg_max;
         end
         if (cfg_deadband_load)
            deadband_code <= cfg_deadband;
         // Save takes the working set; a same-cycle load is caught next save
         if (cfg_save) begin
            def_min <= ref_min;
            def_cen <= ref_cen;
            def_max <= ref_max;
            def_db  <= deadband_code;
         end
      end
   end

   // ----------------------------------------
   // Command arithmetic
   // ----------------------------------------
   // (R11) deadband in 1/127 units: 8,16,24,32,40,46,54 percent of one side
   function [6:0] db_units;
      input [2:0] code;
      begin
         case (code)
            3'd1:    db_units = 7'd10;
            3'd2:    db_units = 7'd20;
            3'd3:    db_units = 7'd30;
            3'd4:    db_units = 7'd41;
            3'd5:    db_units = 7'd51;
            3'd6:    db_units = 7'd59;
            3'd7:    db_units = 7'd69;
            default: db_units = 7'd0;   // (R10) code zero off
         endcase
      end
   endfunction

   // (R3) signed -127..+127 command from width against references
   function [7:0] to_cmd;
      input [W-1:0] w;
      input [W-1:0] mn;
      input [W-1:0] cn;
      input [W-1:0] mx;
      reg   [W-1:0] span;
      reg   [W-1:0] off;
      reg   [W+7:0] q;
      begin
         span = {W{1'b0}};
         off  = {W{1'b0}};
         if (w >= cn) begin
            span = (mx > cn) ? mx - cn : {{(W-1){1'b0}}, 1'b1};
            off  = (w > mx) ? span : w - cn;
         end else begin
            span = (cn > mn) ? cn - mn : {{(W-1){1'b0}}, 1'b1};
            off  = (w < mn) ? span : cn - w;
         end
         q = ({8'h00, off} * 8'd127) / span;
         to_cmd = (w >= cn) ? q[7:0] : (8'd0 - q[7:0]);
      end
   endfunction

   // (R14)(R15) apply deadband then stretch remainder to full scale
   function [7:0] apply_db;
      input [7:0] c;
      input [6:0] d;
      reg   [6:0] mag;
      reg   [14:0] s;
      begin
         mag = c[7] ? 7'd0 - c[6:0] : c[6:0];
         if (c == 8'h80) mag = 7'd127;
         if (mag <= d || d >= 7'd127) begin
            apply_db = 8'h00;
         end else begin
            s = ({8'h00, mag - d} * 15'd127) / {8'h00, 7'd127 - d};
            apply_db = c[7] ? 8'd0 - {1'b0, s[6:0]} : {1'b0, s[6:0]};
         end
      end
   endfunction

   // (R16) curves: 0 linear, 1-2 exponential, 3-4 logarithmic-like
   function [7:0] curve;
      input [7:0] c;
      input [2:0] sel;
      reg   [6:0] m;
      reg   [13:0] sq;
      reg   [13:0] isq;
      reg   [13:0] t;
      begin
         m   = c[7] ? 7'd0 - c[6:0] : c[6:0];
         sq  = m * m;
         isq = (7'd127 - m) * (7'd127 - m);
         // Wide sums so full scale maps to full scale without overflow
         case (sel)
            3'd1:    t = sq / 14'd127;
            3'd2:    t = (sq / 14'd127 + m) >> 1;
            3'd3:    t = 14'd127 - isq / 14'd127;
            3'd4:    t = (14'd127 - isq / 14'd127 + m) >> 1;
            default: t = {7'd0, m};
         endcase
         curve = c[7] ? 8'd0 - {1'b0, t[6:0]} : {1'b0, t[6:0]};
      end
   endfunction

   // (R17) reduce the non-favoured side by trim percent, max ten
   function [7:0] trim;
      input [7:0] c;
      input [3:0] pct;
      reg   [3:0] p;
      reg   [14:0] t;
      begin
         p = (pct > 4'd10) ? 4'd10 : pct;
         t = {{7{c[7]}}, c} * (15'd100 - p) / 15'd100;
         if (c[7])
            t = 15'd0 - ((15'd0 - {{7{1'b1}}, c}) * (15'd100 - p) / 15'd100);
         trim = t[7:0];
      end
   endfunction

   // ----------------------------------------
   // Command outputs
   // ----------------------------------------
   wire [6:0] dbu = db_units(deadband_code);
   wire [7:0] raw1 = to_cmd(wid[0], ref_min, ref_cen, ref_max);
   wire [7:0] raw2 = to_cmd(wid[1], ref_min, ref_cen, ref_max);
   // (R13) same deadband for both
   wire [7:0] adj1 = curve(apply_db(raw1, dbu), curve_sel);
   wire [7:0] adj2 = curve(apply_db(raw2, dbu), curve_sel);
   wire       ok1  = wdone[0] & wok[0];
   wire       ok2  = wdone[1] & wok[1];

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cmd1      <= 8'h00;
         cmd2      <= 8'h00;
         cmd_valid <= 1'b0;
      end else begin
         cmd_valid <= (ok1 | ok2) & motors_enabled;
         // (R5) zero command while disabled
         if (!motors_enabled) begin
            cmd1 <= 8'h00;
            cmd2 <= 8'h00;
         end else begin
            if (ok1)
               cmd1 <= (mixed_mode && !trim_left) ? trim(adj1, trim_pct) : adj1;
            if (ok2)
               cmd2 <= (mixed_mode && trim_left) ? trim(adj2, trim_pct) : adj2;
         end
      end
   end

   // ----------------------------------------
   // Reception watchdog
   // ----------------------------------------
   reg [1:0]  state;
   reg [1:0]  next_state;
   reg [23:0] wd_count;
   reg [7:0]  good_pulses;
   reg [23:0] gap_count;
   // (R19) only plausible pulses feed the watchdog
   wire good = ok1 | ok2;

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: if (good) next_state = ST_QUAL;
         // (R6) regular pulses for full period
         ST_QUAL: if (gap_count >= LOSS_TICKS[23:0] && !good)
                     next_state = ST_IDLE;
                  else if (wd_count >= QUAL_TICKS[23:0] && good_pulses >= `RC_QUAL_PULSES)
                     next_state = ST_RUN;
         ST_RUN:  if (!good && tick && wd_count >= LOSS_TICKS[23:0])
                     next_state = ST_LOSS;   // (R7) loss timeout expired
         ST_LOSS: if (good) next_state = ST_QUAL;
         default: next_state = ST_IDLE;
      endcase
   end

   // Counter measures qualification time, or silence while running
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state       <= ST_IDLE;
         wd_count    <= 24'h000000;
         good_pulses <= 8'h00;
         gap_count   <= 24'h000000;
      end else begin
         state <= next_state;
         if (next_state != state) begin
            wd_count    <= 24'h000000;
            gap_count   <= 24'h000000;
            // Entry to qualification is on a good pulse, which counts
            good_pulses <= (next_state == ST_QUAL) ? 8'h01 : 8'h00;
         end else begin
            if (state == ST_QUAL) begin
               if (good) begin
                  if (good_pulses != 8'hFF) good_pulses <= good_pulses + 8'h01;
                  gap_count <= 24'h000000;
               end else if (tick && gap_count != 24'hFFFFFF)
                  gap_count <= gap_count + 24'h000001;
               // Gap longer than loss time restarts qualification
               if (tick && wd_count != 24'hFFFFFF) wd_count <= wd_count + 24'h000001;
            end else if (state == ST_RUN) begin
               // (R8) pulse returning resets the loss timer
               if (good)
                  wd_count <= 24'h000000;
               else if (tick && wd_count != 24'hFFFFFF)
                  wd_count <= wd_count + 24'h000001;
            end
         end
      end
   end

   // ----------------------------------------
   // Status and accessory output
   // ----------------------------------------
   wire [7:0] raw3 = to_cmd(wid[2], ref_min, ref_cen, ref_max);
   wire       ok3  = wdone[2] & wok[2];

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         motors_enabled <= 1'b0;
         signal_lost    <= 1'b0;
         accessory_on   <= 1'b0;
      end else begin
         // (R5) enabled only while running
         motors_enabled <= (next_state == ST_RUN);
         // (R9) lost flag and accessory off
         signal_lost    <= (next_state == ST_LOSS) || (next_state == ST_IDLE);
         if (next_state != ST_RUN)
            accessory_on <= 1'b0;
         else if (ok3) begin
            // (R18) max turns on, center turns off
            if (!raw3[7] && raw3 >= `RC_CMD_FULL)
               accessory_on <= 1'b1;
            else if (raw3 == 8'h00)
               accessory_on <= 1'b0;
         end
      end
   end

endmodule

// ===== tb/rc_capture_props.sv
// Port-level assertions for the R/C pulse command capture block
`timescale 1ns/1ps
module rc_capture_props #(
   parameter W       = 12,
   parameter LOSS_MS = 250,
   parameter TICK_CYC = 10
) (
   input wire         clk,
   input wire         resetn,
   input wire         ch1_pulse,
   input wire         ch2_pulse,
   input wire [W-1:0] cfg_min,
   input wire [W-1:0] cfg_cen,
   input wire [W-1:0] cfg_max,
   input wire         cfg_load,
   input wire [2:0]   cfg_deadband,
   input wire         cfg_deadband_load,
   input wire [W-1:0] ref_min,
   input wire [W-1:0] ref_cen,
   input wire [W-1:0] ref_max,
   input wire [2:0]   deadband_code,
   input wire [7:0]   cmd1,
   input wire [7:0]   cmd2,
   input wire         cmd_valid,
   input wire         motors_enabled,
   input wire         signal_lost,
   input wire         accessory_on
);
   // Loss window in cycles
   localparam int LOSS_CYC = LOSS_MS * 1000 * TICK_CYC;
   int            gap;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // ----------------------------------------
   // Cycles since a command pulse ended
   // ----------------------------------------
   // Any fall restarts it; only valid while stimulus keeps widths plausible
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         gap <= 0;
      else if ($fell(ch1_pulse) || $fell(ch2_pulse))
         gap <= 0;
      else
         gap <= gap + 1;
   end

   // ----------------------------------------
   // Loss steps
   // ----------------------------------------
   sequence s_drop;
      $fell(motors_enabled);
   endsequence
   sequence s_lost_state;
      signal_lost && !accessory_on;
   endsequence

   a_enable_not_lost: assert property (motors_enabled |-> !signal_lost)
      else $error("motors enabled while flagged lost");
   a_cmd_zero_off: assert property (!motors_enabled && !$past(motors_enabled) |-> cmd1 == 8'h00 && cmd2 == 8'h00)
      else $error("command not zero while disabled");
   a_valid_in_run: assert property (cmd_valid |-> motors_enabled)
      else $error("command valid while disabled");
   a_cmd_stands: assert property (motors_enabled && $past(motors_enabled) && !cmd_valid |-> $stable(cmd1) && $stable(cmd2))
      else $error("command changed without valid");
   a_cmd_range: assert property (cmd1 != 8'h80 && cmd2 != 8'h80)
      else $error("command outside -127..127");
   a_db_load: assert property (cfg_deadband_load |=> deadband_code == $past(cfg_deadband))
      else $error("deadband code not loaded");
   a_ref_load: assert property (cfg_load |=> ref_min == $past(cfg_min) && ref_cen == $past(cfg_cen) && ref_max == $past(cfg_max))
      else $error("references not loaded");
   a_loss_late: assert property (s_drop |-> gap >= LOSS_CYC - 100)
      else $error("motors dropped before loss timeout");
   a_loss_bound: assert property (motors_enabled |-> gap <= LOSS_CYC + 100)
      else $error("motors kept past loss timeout");
   a_run_kept: assert property (motors_enabled && gap < LOSS_CYC - 100 |=> motors_enabled)
      else $error("motors dropped inside loss window");
   a_loss_flags: assert property (s_drop |-> ##[0:1] s_lost_state)
      else $error("loss not flagged or accessory left on");
endmodule

bind rc_pulse_command_capture rc_capture_props #(.W(W), .LOSS_MS(LOSS_MS), .TICK_CYC(TICK_CYC)) u_props (
   .clk, .resetn, .ch1_pulse, .ch2_pulse, .cfg_min, .cfg_cen, .cfg_max, .cfg_load,
   .cfg_deadband, .cfg_deadband_load, .ref_min, .ref_cen, .ref_max, .deadband_code,
   .cmd1, .cmd2, .cmd_valid, .motors_enabled, .signal_lost, .accessory_on
);

// ===== tb/rc_receiver_model.sv
// Receiver model: sequential active-high channel pulses, low between them
`timescale 1ns/1ps
module rc_receiver_model #(
   parameter CYC_PER_US = 10
) (
   input  wire clk,
   output wire ch1_pulse,
   output wire ch2_pulse,
   output wire ch3_pulse
);
   reg [2:0] line = 3'h0;
   assign ch1_pulse = line[0];
   assign ch2_pulse = line[1];
   assign ch3_pulse = line[2];

   task pulse(input int ch, input int us);
      begin
         if (us > 0) begin
            @(posedge clk) line[ch] <= 1'b1;
            repeat (us * CYC_PER_US) @(posedge clk);
            line[ch] <= 1'b0;
         end
      end
   endtask

   task frame(input int w1, input int w2, input int w3);
      begin
         pulse(0, w1);
         pulse(1, w2);
         pulse(2, w3);
         repeat (200 * CYC_PER_US) @(posedge clk); // 200 us sync gap
      end
   endtask
endmodule

// ===== tb/tb_rc_pulse_command_capture.sv
// Self-checking bench for the R/C pulse command capture block
`timescale 1ns/1ps
module tb_rc_pulse_command_capture;
   localparam     LOSS_MS = 6;
   localparam int OFF [8] = '{20, 35, 70, 110, 150, 190, 220, 260};
   reg            clk, resetn, cfg_load, cfg_save, cfg_deadband_load, mon;
   reg  [11:0]    cfg_min, cfg_cen, cfg_max;
   reg  [2:0]     cfg_deadband, curve_sel;
   reg            mixed, trim_l;
   reg  [3:0]     trim_p;
   wire           ch1_pulse, ch2_pulse, ch3_pulse, cmd_valid;
   wire           motors_enabled, signal_lost, accessory_on;
   wire [11:0]    ref_min, ref_cen, ref_max;
   wire [2:0]     deadband_code;
   wire [7:0]     cmd1, cmd2;
   integer        miscompares, checked, cycles, drops, d;

   // One tick per cycle keeps the run short; one us is one cycle
   rc_receiver_model #(.CYC_PER_US(1)) rx (.clk(clk), .ch1_pulse(ch1_pulse), .ch2_pulse(ch2_pulse),
      .ch3_pulse(ch3_pulse));

   rc_pulse_command_capture #(.QUAL_MS(5), .LOSS_MS(LOSS_MS), .TICK_CYC(1)) uut (
      .clk(clk), .resetn(resetn), .ch1_pulse(ch1_pulse), .ch2_pulse(ch2_pulse),
      .ch3_pulse(ch3_pulse), .cfg_min(cfg_min), .cfg_cen(cfg_cen), .cfg_max(cfg_max),
      .cfg_load(cfg_load), .cfg_save(cfg_save), .cfg_deadband(cfg_deadband),
      .cfg_deadband_load(cfg_deadband_load), .curve_sel(curve_sel), .mixed_mode(mixed),
      .trim_left(trim_l), .trim_pct(trim_p), .ref_min(ref_min), .ref_cen(ref_cen),
      .ref_max(ref_max), .deadband_code(deadband_code), .cmd1(cmd1), .cmd2(cmd2),
      .cmd_valid(cmd_valid), .motors_enabled(motors_enabled), .signal_lost(signal_lost),
      .accessory_on(accessory_on)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task check(input [11:0] seen, input [11:0] want);
      begin
         checked = checked + 1;
         if (seen !== want) begin
            miscompares = miscompares + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
         end
      end
   endtask

   task wrap_up;
      begin
         $display("Comparisons %0d, mismatches %0d", checked, miscompares);
         if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   task set_refs(input [11:0] mn, input [11:0] cn, input [11:0] mx);
      begin
         @(posedge clk);
         {cfg_min, cfg_cen, cfg_max} <= {mn, cn, mx};
         {cfg_load, cfg_save} <= 2'h3;
         @(posedge clk);
         {cfg_load, cfg_save} <= 2'h0;
      end
   endtask

   task set_db(input [2:0] code);
      begin
         @(posedge clk);
         cfg_deadband <= code;
         cfg_deadband_load <= 1'b1;
         @(posedge clk);
         cfg_deadband_load <= 1'b0;
      end
   endtask

   // Timeout and watch for enable dropping inside a window
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (mon && motors_enabled !== 1'b1)
         drops <= drops + 1;
      if (cycles == 100000) begin
         miscompares = miscompares + 1;
         wrap_up;
      end
   end

   initial begin
      {resetn, cfg_load, cfg_save, cfg_deadband_load, mon} = 5'h00;
      {cfg_min, cfg_cen, cfg_max} = {12'h3E8, 12'h5DC, 12'h7D0};
      cfg_deadband = 3'h2;
      curve_sel = 3'h0;
      {mixed, trim_l, trim_p} = 6'h00;
      {miscompares, checked, cycles, drops} = {4{32'h0}};
      repeat (16) @(posedge clk);
      check(ref_min, 12'h3E8);
      check(ref_max, 12'h7D0);
      check(deadband_code, 3'h2);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      check(signal_lost, 1'b1);
      rx.frame(600, 2600, 0);
      check(motors_enabled, 1'b0);
      for (d = 0; d < 7; d = d + 1)
         rx.frame(1000, 1000, 0);
      check(motors_enabled, 1'b0);
      rx.frame(1000, 1000, 0);
      check(motors_enabled, 1'b1);
      set_refs(12'h44C, 12'h5DC, 12'h76C);
      rx.frame(1910, 1090, 0);
      check(ref_max, 12'h76C);
      check(cmd1, 8'h7F);
      check(cmd2, 8'h81);
      set_refs(12'h3E8, 12'h5DC, 12'h7D0);
      // Every deadband code and curve: full travel, then just inside the band
      for (d = 0; d < 8; d = d + 1) begin
         set_db(d[2:0]);
         curve_sel <= d[2:0];
         rx.frame(1000, 1500 + OFF[d], 0);
         check(deadband_code, d[2:0]);
         check(cmd1, 8'h81);
         check(cmd2 === 8'h00, d != 0);
      end
      // Mixed mode: the other side loses ten percent, 127 * 90 / 100
      {mixed, trim_l, trim_p} <= {1'b1, 1'b0, 4'hA};
      rx.frame(2010, 2010, 0);
      check(cmd1, 8'h72);
      check(cmd2, 8'h7F);
      {mixed, trim_l, trim_p} <= {1'b1, 1'b1, 4'hF};
      rx.frame(2010, 2010, 0);
      check(cmd1, 8'h7F);
      check(cmd2, 8'h72);
      {mixed, trim_l, trim_p} <= 6'h00;
      set_db(3'h2);
      curve_sel <= 3'h0;
      rx.frame(1000, 1000, 2010);
      check(accessory_on, 1'b1);
      rx.frame(1000, 1000, 1500);
      check(accessory_on, 1'b0);
      rx.frame(1000, 1000, 2010);
      mon <= 1'b1;
      repeat (1500) @(posedge clk);
      rx.frame(1000, 1000, 0);
      mon <= 1'b0;
      check(drops, 0);
      check(accessory_on, 1'b1);
      repeat (5000) @(posedge clk);
      check(motors_enabled, 1'b1);
      repeat (1500) @(posedge clk);
      check(motors_enabled, 1'b0);
      check(signal_lost, 1'b1);
      check(accessory_on, 1'b0);
      wrap_up;
   end
endmodule
